// ==== sleep_pkg.sv ====
// Shared constants and carrier types for the sleep-mode controller
package sleep_pkg;
    // Sleep mode select codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int IRQ_HALT_CYCLES = 4;
    localparam int STBY_WAKE_CYCLES = 6;
    localparam int BOD_WAKE_NS = 60000;
    localparam int BOD_WAKE_CYCLES = BOD_WAKE_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_DEFAULT = 16384;
    localparam int CNT_W = 16;

    // Clock domain enables driven to the clock tree
    typedef struct packed {
        logic cpu_clock_domain;
        logic flash_clock;
        logic io_clock_domain;
        logic converter_clock_domain;
        logic async_clock;
        logic main_osc;
        logic timer_osc;
    } clk_gate_t;

    // Wake sources presented by peripherals
    typedef struct packed {
        logic ext_reset;
        logic wdt_reset;
        logic bod_reset;
        logic wdt_irq;
        logic twi_match;
        logic pin_change_irq;
        logic ext_irq_pin_a;
        logic ext_irq_pin_b;
        logic level_a;
        logic level_b;
        logic timer_irq;
        logic spm_ready;
        logic conv_done;
        logic other_irq;
    } wake_src_t;
endpackage

// ==== sleep_mode_controller.sv ====
// Sleep-mode controller: clock gating, wake decode, wake delays, brown-out sleep-off
module sleep_mode_controller
    import sleep_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_DEFAULT
)(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Core side
    input wire logic sleep_req,
    input wire logic sleep_enable_bit,
    input wire logic [2:0] sleep_mode_select,
    input wire logic brownout_sleep_off,
    input wire logic crystal_selected,
    input wire logic timer_async,
    input wire logic converter_enabled,
    // Wake sources, asynchronous to clk_sys
    input sleep_pkg::wake_src_t wake_src,
    // Clock tree and peripheral controls
    output sleep_pkg::clk_gate_t clk_gate,
    output logic brownout_detector_en,
    output logic conv_start,
    // Core status
    output logic asleep,
    output logic core_halt,
    output logic irq_take,
    output logic reset_vector
);
    import sleep_pkg::*;

    // Run states
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_WAKE = 4'h4,
        ST_HALT = 4'h8
    } state_t;

    localparam int WAKE_W = $bits(wake_src_t);

    state_t state; // Current state
    state_t next_state; // Next state
    logic [2:0] mode; // Mode latched at entry
    logic bod_off; // Detector held off in this sleep
    logic irq_wake; // Wake cause was an interrupt
    logic rst_wake; // Wake cause was a reset
    logic [CNT_W-1:0] count; // Wake delay counter
    logic [WAKE_W-1:0] sync1, sync2, sync3; // Three-stage synchroniser
    wake_src_t ws; // Filtered wake sources

    // Synchroniser chain for asynchronous wake inputs
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end
        else
        begin
            sync1 <= wake_src;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Filter: a bit changes only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < WAKE_W; gi++)
        begin : g_filt
            logic held;
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                    held <= 1'b0;
                else if (sync2[gi] == sync3[gi])
                    held <= sync3[gi];
            end
            assign ws[gi] = held;
        end
    endgenerate

    // Mode decode
    wire legal_mode = (sleep_mode_select == MODE_IDLE) || (sleep_mode_select == MODE_NOISE) ||
        (sleep_mode_select == MODE_PDOWN) || (sleep_mode_select == MODE_PSAVE) ||
        (((sleep_mode_select == MODE_STBY) || (sleep_mode_select == MODE_XSTBY)) && crystal_selected);
    wire go_sleep = sleep_req && sleep_enable_bit && legal_mode;
    wire deep_sel = (sleep_mode_select != MODE_IDLE) && (sleep_mode_select != MODE_NOISE);
    wire is_idle = (mode == MODE_IDLE);
    wire is_noise = (mode == MODE_NOISE);
    wire is_pdown = (mode == MODE_PDOWN);
    wire is_psave = (mode == MODE_PSAVE);
    wire is_stby = (mode == MODE_STBY);
    wire is_xstby = (mode == MODE_XSTBY);
    wire sleeping = (state == ST_SLEEP) || (state == ST_WAKE);

    // Resets wake from any mode
    wire rst_src = ws.ext_reset || ws.wdt_reset || ws.bod_reset;
    // External pins: edge allowed in idle, level only elsewhere
    wire ext_a = is_idle ? ws.ext_irq_pin_a : (ws.ext_irq_pin_a && ws.level_a);
    wire ext_b = is_idle ? ws.ext_irq_pin_b : (ws.ext_irq_pin_b && ws.level_b);
    // Sources common to all modes
    wire base_irq = ws.wdt_irq || ws.twi_match || ws.pin_change_irq || ext_a || ext_b;
    wire timer_ok = is_idle || ((is_noise || is_psave || is_xstby) && timer_async);
    wire idle_irq = base_irq || ws.timer_irq || ws.spm_ready || ws.conv_done || ws.other_irq;
    wire noise_irq = base_irq || (ws.timer_irq && timer_ok) || ws.spm_ready || ws.conv_done;
    wire save_irq = base_irq || (ws.timer_irq && timer_ok);
    wire irq_src = is_idle ? idle_irq :
        is_noise ? noise_irq :
        (is_psave || is_xstby) ? save_irq : base_irq;
    wire wake_any = rst_src || irq_src;

    // Wake delay choice
    wire [CNT_W-1:0] delay_tout = CNT_W'(TIMEOUT_CYCLES);
    wire [CNT_W-1:0] delay_stby = CNT_W'(STBY_WAKE_CYCLES);
    wire [CNT_W-1:0] delay_bod = CNT_W'(BOD_WAKE_CYCLES);
    wire [CNT_W-1:0] delay_base = (is_stby || is_xstby) ? delay_stby :
        (is_pdown || is_psave) ? delay_tout : CNT_W'(1);
    wire [CNT_W-1:0] delay_sel = (bod_off && (delay_bod > delay_base)) ? delay_bod : delay_base;
    // Level source no longer present at end of start-up
    wire level_gone = !irq_src;

    // Next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_RUN:
                if (go_sleep)
                    next_state = ST_SLEEP;
            ST_SLEEP:
                if (wake_any)
                    next_state = ST_WAKE;
            ST_WAKE:
                if (count == '0)
                    next_state = (irq_wake && !rst_wake && !level_gone) ? ST_HALT : ST_RUN;
            ST_HALT:
                if (count == '0)
                    next_state = ST_RUN;
        endcase
    end

    // State, mode latch and counter
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_RUN;
            mode <= MODE_IDLE;
            bod_off <= 1'b0;
            irq_wake <= 1'b0;
            rst_wake <= 1'b0;
            count <= '0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_RUN && go_sleep)
            begin
                mode <= sleep_mode_select;
                bod_off <= brownout_sleep_off && deep_sel;
                irq_wake <= 1'b0;
                rst_wake <= 1'b0;
            end
            else if (state == ST_SLEEP && wake_any)
            begin
                irq_wake <= irq_src;
                rst_wake <= rst_src;
                count <= delay_sel - CNT_W'(1);
            end
            else if (state == ST_WAKE && count == '0)
            begin
                bod_off <= 1'b0;
                count <= CNT_W'(IRQ_HALT_CYCLES - 1);
            end
            else if (count != '0)
                count <= count - CNT_W'(1);
        end
    end

    // Pulses on sleep entry and on leaving the wake path
    logic conv_start_q; // Conversion start pulse
    logic irq_take_q; // Interrupt dispatch pulse
    logic rst_vec_q; // Reset-vector restart pulse
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            conv_start_q <= 1'b0;
            irq_take_q <= 1'b0;
            rst_vec_q <= 1'b0;
        end
        else
        begin
            conv_start_q <= (state == ST_RUN) && go_sleep &&
                (sleep_mode_select == MODE_NOISE) && converter_enabled;
            irq_take_q <= (state == ST_HALT) && (count == '0);
            rst_vec_q <= (state == ST_WAKE) && (count == '0) && rst_wake;
        end
    end

    // Clock gating map, registers and memory stay powered throughout
    logic cpu_on, io_on, adc_on, asy_on, main_on, tosc_on;
    always_comb
    begin
        cpu_on = !sleeping;
        io_on = !sleeping || is_idle;
        adc_on = !sleeping || is_idle || is_noise;
        asy_on = !sleeping || is_idle || ((is_noise || is_psave || is_xstby) && timer_async);
        main_on = !sleeping || is_idle || is_noise || is_stby || is_xstby;
        tosc_on = !sleeping || is_idle || ((is_noise || is_psave || is_xstby) && timer_async);
    end

    // Output registers
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            clk_gate <= '1;
        else
        begin
            clk_gate.cpu_clock_domain <= cpu_on;
            clk_gate.flash_clock <= cpu_on;
            clk_gate.io_clock_domain <= io_on;
            clk_gate.converter_clock_domain <= adc_on;
            clk_gate.async_clock <= asy_on;
            clk_gate.main_osc <= main_on;
            clk_gate.timer_osc <= tosc_on;
        end
    end

    assign brownout_detector_en = !(bod_off && sleeping);
    assign conv_start = conv_start_q;
    assign asleep = sleeping;
    assign core_halt = (state != ST_RUN);
    assign irq_take = irq_take_q;
    assign reset_vector = rst_vec_q;

    // Checks
    sequence wake_seen_s;
        state == ST_SLEEP && wake_any;
    endsequence

    no_enable_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_RUN && sleep_req && !sleep_enable_bit) |=> state == ST_RUN)
        else $error("sleep entered without enable");
    idle_gating_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_idle) |=> !clk_gate.cpu_clock_domain && clk_gate.io_clock_domain)
        else $error("idle gating wrong");
    noise_gating_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_noise) |=> !clk_gate.io_clock_domain && clk_gate.converter_clock_domain)
        else $error("noise gating wrong");
    pdown_gating_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_pdown) |=> !clk_gate.main_osc && !clk_gate.async_clock)
        else $error("power-down gating wrong");
    stby_osc_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && (is_stby || is_xstby)) |=> clk_gate.main_osc)
        else $error("standby oscillator off");
    stby_wake_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wake_seen_s and (is_stby && !bod_off)) |=> (state == ST_WAKE) [*6] ##1 state != ST_WAKE)
        else $error("standby wake not six cycles");
    bod_shallow_a: assert property (@(posedge clk_sys) disable iff (reset)
        (sleeping && (is_idle || is_noise)) |-> brownout_detector_en)
        else $error("detector off in shallow mode");
    irq_halt_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WAKE && next_state == ST_HALT) |=> (state == ST_HALT) [*4] ##1 irq_take)
        else $error("interrupt halt not four cycles");
    conv_start_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_RUN && go_sleep && sleep_mode_select == MODE_NOISE && converter_enabled) |=> conv_start)
        else $error("conversion not started");

    // Cycles spent in the wake state, seen by the delay checks
    logic [CNT_W-1:0] wake_len; // Zero on the first wake cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            wake_len <= '0;
        else if (state == ST_WAKE)
            wake_len <= wake_len + CNT_W'(1);
        else
            wake_len <= '0;
    end

    run_clocks_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_RUN && !go_sleep) |=> clk_gate == '1)
        else $error("clocks gated while running");
    stby_refused_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_RUN && sleep_req && sleep_enable_bit && !crystal_selected &&
        (sleep_mode_select == MODE_STBY || sleep_mode_select == MODE_XSTBY)) |=> state == ST_RUN)
        else $error("standby entered without crystal");
    idle_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_idle) |=> !clk_gate.flash_clock && clk_gate.converter_clock_domain &&
        clk_gate.async_clock && clk_gate.main_osc)
        else $error("idle stopped a running clock");
    noise_async_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_noise && !timer_async) |=> !clk_gate.async_clock && !clk_gate.timer_osc)
        else $error("timer clock kept without asynchronous mode");
    pdown_all_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_pdown) |=> clk_gate == '0)
        else $error("power-down left a clock running");
    psave_timer_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_psave && timer_async) |=> clk_gate.async_clock && clk_gate.timer_osc &&
        !clk_gate.main_osc)
        else $error("power-save timer clocks wrong");
    pdown_ignore_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_SLEEP && is_pdown && !ws.ext_reset && !ws.wdt_reset && !ws.bod_reset && !ws.wdt_irq &&
        !ws.twi_match && !ws.pin_change_irq && !(ws.ext_irq_pin_a && ws.level_a) &&
        !(ws.ext_irq_pin_b && ws.level_b)) |=> state == ST_SLEEP)
        else $error("power-down woken by a foreign event");
    pdown_delay_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WAKE && count == '0 && (is_pdown || is_psave) && !bod_off) |->
        wake_len == CNT_W'(TIMEOUT_CYCLES - 1))
        else $error("power-down wake delay wrong");
    bod_delay_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WAKE && count == '0 && bod_off) |-> wake_len >= CNT_W'(BOD_WAKE_CYCLES - 1))
        else $error("detector wake delay too short");
    bod_wake_on_a: assert property (@(posedge clk_sys) disable iff (reset)
        !sleeping |-> brownout_detector_en)
        else $error("detector off while running");
    level_lost_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WAKE && count == '0 && irq_wake && !irq_src) |=> !core_halt)
        else $error("vanished level still dispatched");
    reset_wake_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WAKE && count == '0 && rst_wake) |=> reset_vector && !core_halt)
        else $error("reset wake did not restart");
    irq_alone_a: assert property (@(posedge clk_sys) disable iff (reset)
        irq_take |-> !core_halt && !reset_vector)
        else $error("interrupt dispatch overlaps restart");
    conv_once_a: assert property (@(posedge clk_sys) disable iff (reset)
        conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
endmodule

// ==== sleep_core_model.sv ====
// Model of the processor core and the wake event sources facing the controller
module sleep_core_model (
    // Clock
    input wire logic clk_sys,
    // Core controls and event levels
    output logic sleep_req,
    output logic sleep_enable_bit,
    output logic brownout_sleep_off,
    output sleep_pkg::wake_src_t wake_src
);
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_pkg::*;
    // Quiet core and no events at time zero
    initial
    begin
        sleep_req = 1'b0;
        sleep_enable_bit = 1'b0;
        brownout_sleep_off = 1'b0;
        wake_src = '0;
    end
    // Enable level first, then a one-cycle sleep instruction
    task automatic sleep_cmd(input logic en);
        @(posedge clk_sys);
        #1 sleep_enable_bit = en;
        @(posedge clk_sys);
        #1 sleep_req = 1'b1;
        @(posedge clk_sys);
        #1 sleep_req = 1'b0;
    endtask
    // Sleep-off bit changes only through this timed write
    task automatic bod_write(input logic v);
        @(posedge clk_sys);
        #1 brownout_sleep_off = v;
    endtask
    // Present or withdraw event levels
    task automatic wake_set(input wake_src_t w);
        @(posedge clk_sys);
        #1 wake_src = w;
    endtask
endmodule

// ==== sleep_mode_controller_tb_top.sv ====
// Self-checking bench for the sleep-mode controller
module sleep_mode_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_pkg::*;
    // Row: mode, ignored events, waking events, gates, reset cause, least delay
    typedef struct packed {
        logic [2:0] mode;
        logic [13:0] bad;
        logic [13:0] good;
        logic [6:0] gate;
        logic rst;
        logic [15:0] dly;
    } row_t;
    logic clk_sys, reset, crystal_selected, timer_async, converter_enabled;
    logic [2:0] sleep_mode_select;
    logic sleep_req, sleep_enable_bit, brownout_sleep_off;
    wake_src_t wake_src;
    clk_gate_t clk_gate;
    logic brownout_detector_en, conv_start, asleep, core_halt, irq_take, reset_vector;
    int mismatches, n_compared, n_irq, n_rv, n_conv, cnt;
    row_t rows[10];
    row_t r;
    // Short wake timeout keeps the run brief
    sleep_mode_controller #(.TIMEOUT_CYCLES(20)) u_sleep_mode_controller (.clk_sys, .reset, .sleep_req,
        .sleep_enable_bit, .sleep_mode_select, .brownout_sleep_off, .crystal_selected, .timer_async,
        .converter_enabled, .wake_src, .clk_gate, .brownout_detector_en, .conv_start, .asleep,
        .core_halt, .irq_take, .reset_vector);
    // Core and event source model
    sleep_core_model u_sleep_core_model (.clk_sys, .sleep_req, .sleep_enable_bit,
        .brownout_sleep_off, .wake_src);
    // 125 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Count output pulses
    always @(posedge clk_sys)
    begin
        n_irq += int'(irq_take === 1'b1);
        n_rv += int'(reset_vector === 1'b1);
        n_conv += int'(conv_start === 1'b1);
    end
    // Compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Step n edges, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Sleep, offer ignored events, then wake
    task automatic run_row(input row_t r);
        sleep_mode_select = r.mode;
        n_irq = 0;
        n_rv = 0;
        n_conv = 0;
        u_sleep_core_model.sleep_cmd(1'b1);
        cyc(4);
        check(16'(clk_gate), 16'(r.gate));
        check(16'(brownout_detector_en), 16'(!(brownout_sleep_off && r.mode >= MODE_PDOWN)));
        u_sleep_core_model.wake_set(r.bad);
        cyc(12);
        check(16'(asleep), 16'h1);
        u_sleep_core_model.wake_set(r.good);
        cnt = 0;
        // Bounded wait for the core to run again
        while (core_halt !== 1'b0 && cnt < 10000)
        begin
            cyc(1);
            cnt++;
        end
        check(16'(cnt >= int'(r.dly) && cnt < 10000), 16'h1);
        cyc(8);
        check(16'(n_irq), 16'(!r.rst));
        check(16'(n_rv), 16'(r.rst));
        check(16'(n_conv), 16'(r.mode == MODE_NOISE && converter_enabled));
        check(16'({clk_gate, brownout_detector_en}), 16'hFF);
        u_sleep_core_model.wake_set('0);
        cyc(4);
    endtask
    // Verdict and end of run
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        #400000;
        mismatches++;
        results();
    end
    // Main sequence
    initial
    begin
        {mismatches, n_compared, n_irq, n_rv, n_conv} = '0;
        reset = 1'b1;
        crystal_selected = 1'b1;
        timer_async = 1'b1;
        converter_enabled = 1'b1;
        sleep_mode_select = MODE_IDLE;
        rows = '{'{MODE_IDLE, 14'h0000, 14'h0001, 7'h1F, 1'b0, 16'd1},
            '{MODE_NOISE, 14'h0001, 14'h0002, 7'h0F, 1'b0, 16'd1},
            '{MODE_NOISE, 14'h0040, 14'h0008, 7'h0F, 1'b0, 16'd1},
            '{MODE_PDOWN, 14'h0009, 14'h0200, 7'h00, 1'b0, 16'd20},
            '{MODE_PDOWN, 14'h0080, 14'h00A0, 7'h00, 1'b0, 16'd20},
            '{MODE_PSAVE, 14'h0004, 14'h0008, 7'h05, 1'b0, 16'd20},
            '{MODE_STBY, 14'h0008, 14'h0400, 7'h02, 1'b0, 16'd6},
            '{MODE_XSTBY, 14'h0002, 14'h0008, 7'h07, 1'b0, 16'd6},
            '{MODE_IDLE, 14'h0000, 14'h2000, 7'h1F, 1'b1, 16'd1},
            '{MODE_PDOWN, 14'h0000, 14'h0800, 7'h00, 1'b1, 16'd20}};
        cyc(16);
        reset = 1'b0;
        cyc(1);
        check(16'({clk_gate, brownout_detector_en, asleep, core_halt}), 16'h0FF << 2);
        foreach (rows[i])
            run_row(rows[i]);
        // Refused requests: no enable, reserved codes, standby without crystal
        for (int i = 0; i < 4; i++)
        begin
            crystal_selected = (i != 3);
            sleep_mode_select = (i == 0) ? MODE_IDLE : (i == 3) ? MODE_STBY : 3'(i + 3);
            u_sleep_core_model.sleep_cmd(i != 0);
            cyc(4);
            check(16'({asleep, clk_gate}), 16'h7F);
        end
        crystal_selected = 1'b1;
        // Detector switched off only in deep modes, with the long wake
        u_sleep_core_model.bod_write(1'b1);
        foreach (rows[i])
        begin
            r = rows[i];
            r.dly = (r.mode >= MODE_PDOWN) ? 16'd7500 : r.dly;
            if (i == 0 || i == 1 || i == 3 || i == 6)
                run_row(r);
        end
        // Level event vanishes before the wake delay ends
        u_sleep_core_model.bod_write(1'b0);
        // Timer not asynchronous, converter off: timer events ignored, no conversion
        timer_async = 1'b0;
        converter_enabled = 1'b0;
        run_row('{MODE_NOISE, 14'h0008, 14'h0050, 7'h0A, 1'b0, 16'd1});
        run_row('{MODE_PSAVE, 14'h0008, 14'h0100, 7'h00, 1'b0, 16'd20});
        run_row('{MODE_PDOWN, 14'h0000, 14'h1000, 7'h00, 1'b1, 16'd20});
        sleep_mode_select = MODE_PDOWN;
        u_sleep_core_model.sleep_cmd(1'b1);
        cyc(4);
        n_irq = 0;
        u_sleep_core_model.wake_set(14'h00A0);
        cyc(8);
        u_sleep_core_model.wake_set('0);
        cyc(60);
        check(16'({asleep, core_halt}), 16'h0);
        check(16'(n_irq), 16'h0);
        results();
    end
endmodule
